// File: voe_ctl.v
// Video output enhancement control: registers, pixel path and auxiliary sync pin.
// Assumes pixel inputs come from logic on clk, and the video clock pin is asynchronous.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "voe_defines.vh"

module voe_ctl
#(
  parameter [3:0] REVISION = 4'h3, // Arbitrary revision code.
  parameter DLY_W = 4
)
(
  input wire clk,
  input wire rst_b,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  input wire video_out_clock_pin,
  input wire [23:0] pix_main,
  input wire [23:0] pix_ovl,
  input wire [7:0] pix_alpha,
  input wire pix_ovl_on,
  input wire pix_valid,
  input wire pix_field,
  input wire legacy_sync,
  output wire pix_ready,
  output wire [23:0] vo_data,
  output wire vo_valid,
  output wire aux_sync_pin
);

  localparam DLY_DEPTH = 1 << DLY_W;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg [`VOE_CTL_FEAT_W-1:0] feat_q;
  reg [3:0] mask_y_q;
  reg [3:0] mask_c_q;
  reg [7:0] luma_floor_q;
  reg [7:0] luma_ceiling_q;
  reg [7:0] chroma_floor_q;
  reg [7:0] chroma_ceiling_q;
  reg [23:0] key_q;
  reg [DLY_W-1:0] slave_dly_q;
  reg sync_master_q;
  reg data_stream_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // --------------------------------------------------------------------------
  // Stream and pin state
  // --------------------------------------------------------------------------
  reg vclk_s1_q;
  reg vclk_s2_q;
  reg vclk_s3_q;
  reg [23:0] vo_data_q;
  reg vo_valid_q;
  reg aux_q;
  reg key_hit_q;
  reg field_q;
  reg [DLY_DEPTH-1:0] dly_line_q;

  wire vclk_rise;
  wire enhancement_master_enable;
  wire full_blend;
  wire clip_en;
  wire key_en;
  wire genlock_active;
  wire [7:0] floor_y;
  wire [7:0] ceil_y;
  wire [7:0] floor_c;
  wire [7:0] ceil_c;
  wire [23:0] pix_out;
  wire key_hit;
  wire aux_base;
  wire aux_delayed;
  wire [DLY_W-1:0] dly_idx;

  // Every feature is gated by the master enable, so with it clear the unit
  // acts as the plain output path whatever the other bits hold.
  assign enhancement_master_enable = feat_q[`VOE_CTL_ENABLE];
  assign full_blend = enhancement_master_enable & feat_q[`VOE_CTL_FULL_BLEND];
  assign clip_en = enhancement_master_enable & feat_q[`VOE_CTL_CLIP_EN];
  assign key_en = enhancement_master_enable & feat_q[`VOE_CTL_KEY_EN];
  assign genlock_active = enhancement_master_enable & feat_q[`VOE_CTL_GENLOCK] &
                          ~sync_master_q;

  // Programmed bounds only when clipping is on; fixed legacy bounds otherwise.
  assign floor_y = clip_en ? luma_floor_q : `VOE_LEGACY_FLOOR;
  assign ceil_y = clip_en ? luma_ceiling_q : `VOE_LEGACY_CEIL;
  assign floor_c = clip_en ? chroma_floor_q : `VOE_LEGACY_FLOOR;
  assign ceil_c = clip_en ? chroma_ceiling_q : `VOE_LEGACY_CEIL;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------

  // Only defined bits are stored, so undefined bits always read back as zero.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      feat_q <= `VOE_CTL_FEAT_RST;
      mask_y_q <= 4'h0;
      mask_c_q <= 4'h0;
      luma_floor_q <= `VOE_LUMA_FLOOR_RST;
      luma_ceiling_q <= `VOE_LUMA_CEIL_RST;
      chroma_floor_q <= `VOE_CHROMA_FLOOR_RST;
      chroma_ceiling_q <= `VOE_CHROMA_CEIL_RST;
      key_q <= 24'h000000;
      slave_dly_q <= {DLY_W{1'b0}};
      sync_master_q <= 1'b0;
      data_stream_q <= 1'b0;
    end
    else if (ce && reg_wr)
    begin
      case (reg_addr)
        `VOE_OFS_CTL:
        begin
          feat_q <= reg_wdata[`VOE_CTL_FEAT_W-1:0];
        end
        `VOE_OFS_MASK:
        begin
          mask_y_q <= reg_wdata[`VOE_MASK_Y_LSB +: 4];
          mask_c_q <= reg_wdata[`VOE_MASK_C_LSB +: 4];
        end
        `VOE_OFS_CLIP:
        begin
          luma_floor_q <= reg_wdata[`VOE_CLIP_LUMA_FLOOR_LSB +: 8];
          luma_ceiling_q <= reg_wdata[`VOE_CLIP_LUMA_CEIL_LSB +: 8];
          chroma_floor_q <= reg_wdata[`VOE_CLIP_CHROMA_FLOOR_LSB +: 8];
          chroma_ceiling_q <= reg_wdata[`VOE_CLIP_CHROMA_CEIL_LSB +: 8];
        end
        `VOE_OFS_KEY:
        begin
          key_q <= reg_wdata[23:0];
        end
        `VOE_OFS_SLVDLY:
        begin
          slave_dly_q <= reg_wdata[DLY_W-1:0];
        end
        `VOE_OFS_MODE:
        begin
          sync_master_q <= reg_wdata[`VOE_MODE_SYNC_MASTER];
          data_stream_q <= reg_wdata[`VOE_MODE_DATA_STREAM];
        end
        default:
        begin
          feat_q <= feat_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------

  // Read data mux; an unmapped offset reads as zero.
  always @*
  begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `VOE_OFS_CTL:
      begin
        rdata_d[`VOE_CTL_REV_LSB +: 4] = REVISION;
        rdata_d[`VOE_CTL_FEAT_W-1:0] = feat_q;
      end
      `VOE_OFS_MASK:
      begin
        rdata_d[`VOE_MASK_Y_LSB +: 4] = mask_y_q;
        rdata_d[`VOE_MASK_C_LSB +: 4] = mask_c_q;
      end
      `VOE_OFS_CLIP:
      begin
        rdata_d = {chroma_ceiling_q, chroma_floor_q, luma_ceiling_q, luma_floor_q};
      end
      `VOE_OFS_KEY:
      begin
        rdata_d[23:0] = key_q;
      end
      `VOE_OFS_SLVDLY:
      begin
        rdata_d[DLY_W-1:0] = slave_dly_q;
      end
      `VOE_OFS_MODE:
      begin
        rdata_d[`VOE_MODE_SYNC_MASTER] = sync_master_q;
        rdata_d[`VOE_MODE_DATA_STREAM] = data_stream_q;
      end
      `VOE_OFS_STATUS:
      begin
        rdata_d[3:0] = {field_q, key_hit_q, genlock_active, aux_q};
      end
      default:
      begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Read data stand for exactly the cycle after the strobe, zero otherwise.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      rdata_q <= reg_rd ? rdata_d : 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;

  // --------------------------------------------------------------------------
  // Video clock sampling
  // --------------------------------------------------------------------------

  // Two flops before use; the third only serves the edge detector.
  // The pin must stay below half the clk rate or edges are missed.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vclk_s1_q <= 1'b0;
      vclk_s2_q <= 1'b0;
      vclk_s3_q <= 1'b0;
    end
    else if (ce)
    begin
      vclk_s1_q <= video_out_clock_pin;
      vclk_s2_q <= vclk_s1_q;
      vclk_s3_q <= vclk_s2_q;
    end
  end

  assign vclk_rise = vclk_s2_q & ~vclk_s3_q;
  assign pix_ready = vclk_rise & ce;

  // --------------------------------------------------------------------------
  // Pixel path
  // --------------------------------------------------------------------------
  voe_pix u_pix
  (
    .main_yuv(pix_main),
    .ovl_yuv(pix_ovl),
    .ovl_alpha(pix_alpha),
    .ovl_on(pix_ovl_on),
    .full_blend(full_blend),
    .key_en(key_en),
    .key_yuv(key_q),
    .mask_y(mask_y_q),
    .mask_c(mask_c_q),
    .floor_y(floor_y),
    .ceil_y(ceil_y),
    .floor_c(floor_c),
    .ceil_c(ceil_c),
    .out_yuv(pix_out),
    .key_hit(key_hit)
  );

  // Valid and field are taken on every video clock rise; data and key hit only when pix_valid is set, and are held otherwise.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      vo_data_q <= 24'h000000;
      vo_valid_q <= 1'b0;
      key_hit_q <= 1'b0;
      field_q <= 1'b0;
    end
    else if (ce && vclk_rise)
    begin
      vo_valid_q <= pix_valid;
      field_q <= pix_field;
      if (pix_valid)
      begin
        vo_data_q <= pix_out;
        key_hit_q <= key_hit;
      end
    end
  end

  assign vo_data = vo_data_q;
  assign vo_valid = vo_valid_q;

  // --------------------------------------------------------------------------
  // Auxiliary sync pin
  // --------------------------------------------------------------------------

  // Field sync outranks data-valid; both fall back to the plain sync output.
  assign aux_base = (enhancement_master_enable & feat_q[`VOE_CTL_FIELD_SYNC]) ?
                    pix_field :
                    (enhancement_master_enable & feat_q[`VOE_CTL_SYNC_STREAM] &
                     data_stream_q) ? pix_valid :
                    legacy_sync;

  // The delay line shifts on each video clock rise, so the tap gives the
  // value sampled that many video clocks earlier.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dly_line_q <= {DLY_DEPTH{1'b0}};
    end
    else if (ce && vclk_rise)
    begin
      dly_line_q <= {dly_line_q[DLY_DEPTH-2:0], aux_base};
    end
  end

  assign dly_idx = slave_dly_q - {{(DLY_W-1){1'b0}}, 1'b1};
  assign aux_delayed = (slave_dly_q == {DLY_W{1'b0}}) ? aux_base : dly_line_q[dly_idx];

  // Delay applies only while genlock is really active.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aux_q <= 1'b0;
    end
    else if (ce && vclk_rise)
    begin
      aux_q <= genlock_active ? aux_delayed : aux_base;
    end
  end

  assign aux_sync_pin = aux_q;

endmodule // voe_ctl

// File: voe_defines.vh
// Constants shared by the video output enhancement control block.
// Assumes it is included by bare name from every design file that needs it.
`ifndef VOE_DEFINES_VH
`define VOE_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define VOE_OFS_CTL 8'h00
`define VOE_OFS_MASK 8'h04
`define VOE_OFS_CLIP 8'h08
`define VOE_OFS_KEY 8'h0c
`define VOE_OFS_SLVDLY 8'h10
`define VOE_OFS_MODE 8'h14
`define VOE_OFS_STATUS 8'h18

// ----------------------------------------------------------------------------
// Enhancement control fields
// ----------------------------------------------------------------------------
`define VOE_CTL_ENABLE 0
`define VOE_CTL_FULL_BLEND 1
`define VOE_CTL_CLIP_EN 2
`define VOE_CTL_SYNC_STREAM 3
`define VOE_CTL_FIELD_SYNC 4
`define VOE_CTL_GENLOCK 5
`define VOE_CTL_KEY_EN 6
`define VOE_CTL_FEAT_W 7
`define VOE_CTL_REV_LSB 28

// ----------------------------------------------------------------------------
// Mask, clip and key field positions
// ----------------------------------------------------------------------------
`define VOE_MASK_Y_LSB 28
`define VOE_MASK_C_LSB 24
`define VOE_CLIP_LUMA_FLOOR_LSB 0
`define VOE_CLIP_LUMA_CEIL_LSB 8
`define VOE_CLIP_CHROMA_FLOOR_LSB 16
`define VOE_CLIP_CHROMA_CEIL_LSB 24
`define VOE_KEY_Y_LSB 0
`define VOE_KEY_U_LSB 8
`define VOE_KEY_V_LSB 16

// ----------------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------------
`define VOE_MODE_SYNC_MASTER 0
`define VOE_MODE_DATA_STREAM 1

// ----------------------------------------------------------------------------
// Reset values and fixed bounds
// ----------------------------------------------------------------------------
`define VOE_CTL_FEAT_RST 7'h00
`define VOE_LUMA_FLOOR_RST 8'h10
`define VOE_LUMA_CEIL_RST 8'heb
`define VOE_CHROMA_FLOOR_RST 8'h10
`define VOE_CHROMA_CEIL_RST 8'hf0
`define VOE_LEGACY_FLOOR 8'h10
`define VOE_LEGACY_CEIL 8'hf0
`define VOE_ALPHA_FULL 9'h100

`endif

// File: voe_pix.v
// Per-pixel chroma key, alpha blend and output clipping for one Y/U/V sample set.
// Assumes samples are packed with Y in bits 7:0, U in 15:8 and V in 23:16.
`timescale 1ns/1ps
`include "voe_defines.vh"

module voe_pix
(
  input wire [23:0] main_yuv,
  input wire [23:0] ovl_yuv,
  input wire [7:0] ovl_alpha,
  input wire ovl_on,
  input wire full_blend,
  input wire key_en,
  input wire [23:0] key_yuv,
  input wire [3:0] mask_y,
  input wire [3:0] mask_c,
  input wire [7:0] floor_y,
  input wire [7:0] ceil_y,
  input wire [7:0] floor_c,
  input wire [7:0] ceil_c,
  output wire [23:0] out_yuv,
  output wire key_hit
);

  wire [2:0] match;
  wire [8:0] alpha_q;
  wire [8:0] alpha_eff;
  wire [8:0] alpha_inv;

  // Full mode maps 255 to exactly 100% so an opaque overlay replaces the image.
  // Five-level mode keeps only 0, 25, 50, 75 and 100 percent.
  assign alpha_q = full_blend ? ({1'b0, ovl_alpha} + {8'h00, ovl_alpha[7]}) :
                   (ovl_alpha == 8'hff) ? `VOE_ALPHA_FULL :
                   {1'b0, ovl_alpha[7:6], 6'h00};

  // A keyed pixel is fully transparent.
  assign key_hit = key_en & ovl_on & (&match);
  assign alpha_eff = (ovl_on & ~key_hit) ? alpha_q : 9'h000;
  assign alpha_inv = `VOE_ALPHA_FULL - alpha_eff;

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_comp
      wire [7:0] m = main_yuv[8*g +: 8];
      wire [7:0] o = ovl_yuv[8*g +: 8];
      wire [7:0] ign = {4'h0, (g == 0) ? mask_y : mask_c};
      wire [7:0] fl = (g == 0) ? floor_y : floor_c;
      wire [7:0] cl = (g == 0) ? ceil_y : ceil_c;
      wire [16:0] po = {9'h000, o} * {8'h00, alpha_eff};
      wire [16:0] pm = {9'h000, m} * {8'h00, alpha_inv};
      wire [16:0] sum = po + pm;
      wire [7:0] b = sum[15:8];
      // Masked bit positions take no part in the key compare.
      assign match[g] = (((o ^ key_yuv[8*g +: 8]) & ~ign) == 8'h00);
      // Clipping acts on the blended sample, last before the port.
      // Floor first, so with floor above ceiling a sample up to the floor gives the floor and one above it the ceiling.
      assign out_yuv[8*g +: 8] = (b <= fl) ? fl :
                                 (b >= cl) ? cl : b;
    end
  endgenerate

endmodule // voe_pix

// File: voe_ctl_checker.sv
// Port checker for the enhancement control block.
// Assumes it is bound to voe_ctl and that clock enable stays high.
`timescale 1ns/1ps
`include "voe_defines.vh"
module voe_ctl_checker
#(
  parameter [3:0] REVISION = 4'h3
)
(
  input wire clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire pix_ready,
  input wire pix_valid,
  input wire pix_field,
  input wire legacy_sync,
  input wire [23:0] vo_data,
  input wire vo_valid,
  input wire aux_sync_pin
);
  reg [6:0] ctl_q;
  reg [31:0] clip_q;
  reg [1:0] mode_q;
  wire gl = ctl_q[0] & ctl_q[5] & ~mode_q[0];
  wire leg = ~(ctl_q[0] & ctl_q[2]);
  wire fs = ctl_q[0] & ctl_q[4];
  wire ds = ctl_q[0] & ~ctl_q[4] & ctl_q[3] & mode_q[1];

  // ----
  // Register mirror
  // ----
  // Mirror of the settings; it updates on the same edge as the block so no lag appears.
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_q <= 7'h00;
      clip_q <= 32'hf010eb10;
      mode_q <= 2'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `VOE_OFS_CTL) ctl_q <= reg_wdata[6:0];
      if (reg_addr == `VOE_OFS_CLIP) clip_q <= reg_wdata;
      if (reg_addr == `VOE_OFS_MODE) mode_q <= reg_wdata[1:0];
    end
  end

  // Range test shared by the bound properties.
  function ok(input [7:0] v, input [7:0] lo, input [7:0] hi);
    ok = (v >= lo) && (v <= hi);
  endfunction

  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rev;
    $past(reg_rd) && $past(reg_addr) == `VOE_OFS_CTL |-> reg_rdata[31:28] == REVISION;
  endproperty
  a_rev: assert property (p_rev) else $error("revision field wrong");
  property p_hold;
    !$past(pix_ready) |-> $stable(vo_data) && $stable(aux_sync_pin);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved between clocks");
  property p_leg;
    $past(pix_ready && pix_valid && leg) |-> ok(vo_data[7:0], 8'h10, 8'hf0)
      && ok(vo_data[15:8], 8'h10, 8'hf0) && ok(vo_data[23:16], 8'h10, 8'hf0);
  endproperty
  a_leg: assert property (p_leg) else $error("fixed bounds broken");
  property p_pro_y;
    $past(pix_ready && pix_valid && !leg)
      |-> ok(vo_data[7:0], $past(clip_q[7:0]), $past(clip_q[15:8]));
  endproperty
  a_pro_y: assert property (p_pro_y) else $error("luma bounds broken");
  property p_pro_c;
    $past(pix_ready && pix_valid && !leg)
      |-> ok(vo_data[15:8], $past(clip_q[23:16]), $past(clip_q[31:24]))
      && ok(vo_data[23:16], $past(clip_q[23:16]), $past(clip_q[31:24]));
  endproperty
  a_pro_c: assert property (p_pro_c) else $error("chroma bounds broken");
  property p_vld;
    $past(pix_ready) |-> vo_valid == $past(pix_valid);
  endproperty
  a_vld: assert property (p_vld) else $error("valid flag wrong");
  property p_fld;
    $past(pix_ready && fs && !gl) |-> aux_sync_pin == $past(pix_field);
  endproperty
  a_fld: assert property (p_fld) else $error("field sync wrong");
  property p_dv;
    $past(pix_ready && ds && !gl) |-> aux_sync_pin == $past(pix_valid);
  endproperty
  a_dv: assert property (p_dv) else $error("data valid pin wrong");
  property p_lsy;
    $past(pix_ready && !ctl_q[0]) |-> aux_sync_pin == $past(legacy_sync);
  endproperty
  a_lsy: assert property (p_lsy) else $error("plain sync wrong");
endmodule // voe_ctl_checker

bind voe_ctl voe_ctl_checker #(.REVISION(REVISION)) u_chk
(
  .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pix_ready,
  .pix_valid, .pix_field, .legacy_sync, .vo_data, .vo_valid, .aux_sync_pin
);

// File: voe_sink_model.sv
// Video sink model: drives the video clock and counts valid samples.
// Assumes the bench raises run once reset is over.
`timescale 1ns/1ps
module voe_sink_model
(
  input wire run,
  input wire vo_valid,
  output reg video_out_clock_pin,
  output reg [15:0] taken
);
  // ----
  // Clock and capture
  // ----
  initial
  begin
    video_out_clock_pin = 1'b0;
    taken = 16'h0;
  end

  // The clock stands low until run, then keeps a 48 ns period off the bench phase.
  always
  begin
    if (!run)
    begin
      @(posedge run);
      #1.3;
    end
    #24 video_out_clock_pin = 1'b1;
    #24 video_out_clock_pin = 1'b0;
  end

  // Samples are counted at the rising video clock, as a real sink latches them.
  always @(posedge video_out_clock_pin)
  begin
    if (vo_valid)
      taken = taken + 16'h1;
  end
endmodule // voe_sink_model

// File: voe_ctl_tb.sv
// Self-checking bench for the enhancement control block.
// Assumes voe_ctl, its checker and the sink model are compiled first.
`timescale 1ns/1ps
`include "voe_defines.vh"
module voe_ctl_tb;
  // ----
  // Signals
  // ----
  localparam [23:0] M0 = 24'h808080;
  localparam [23:0] MA = 24'h4040f5;
  localparam [23:0] OA = 24'hc0c0f5;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [23:0] pm = 24'h0;
  reg [23:0] po = 24'h0;
  reg [7:0] pa = 8'h00;
  reg pon = 1'b0;
  reg pv = 1'b0;
  reg pf = 1'b0;
  reg ls = 1'b0;
  reg run = 1'b0;
  reg aux_on = 1'b1;
  reg [31:0] bd = 32'hf010f010;
  reg [11:0] fp = 12'hb60;
  wire vclk;
  wire rdy;
  wire [31:0] rdata;
  wire [23:0] vo_data;
  wire vo_valid;
  wire aux;
  wire [15:0] taken;
  integer err_count = 0;
  integer comparisons = 0;
  integer i;

  // A 4 ns clock.
  always #2 clk = ~clk;

  voe_ctl #(.REVISION(4'h3), .DLY_W(4)) DUT
  (
    .clk(clk), .rst_b(rst_b), .ce(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .video_out_clock_pin(vclk),
    .pix_main(pm), .pix_ovl(po), .pix_alpha(pa), .pix_ovl_on(pon), .pix_valid(pv),
    .pix_field(pf), .legacy_sync(ls), .pix_ready(rdy), .vo_data(vo_data),
    .vo_valid(vo_valid), .aux_sync_pin(aux)
  );

  voe_sink_model u_sink
  (
    .run(run), .vo_valid(vo_valid), .video_out_clock_pin(vclk), .taken(taken)
  );

  // ----
  // Tasks
  // ----
  task chk(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task chk_pin(input got, input exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  task tally_and_finish;
  begin
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  // Strobes drop a cycle before the next access, so no signal is set twice at one edge.
  task wr(input [7:0] a, input [31:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  end
  endtask

  task rd(input [7:0] a, input [31:0] e);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  end
  endtask

  // One blend stage and its bounds for a single component.
  function [7:0] bl(input [7:0] o, input [7:0] m, input [8:0] a, input [7:0] lo,
    input [7:0] hi);
    reg [16:0] t;
  begin
    t = (o * a + m * (9'h100 - a)) >> 8;
    bl = (t <= lo) ? lo : (t >= hi) ? hi : t[7:0];
  end
  endfunction

  function [23:0] ex(input [23:0] m, input [23:0] o, input [8:0] a);
    ex = {bl(o[23:16], m[23:16], a, bd[23:16], bd[31:24]),
      bl(o[15:8], m[15:8], a, bd[23:16], bd[31:24]), bl(o[7:0], m[7:0], a, bd[7:0], bd[15:8])};
  endfunction

  // Holds one pixel until the block takes it, then checks what it drives.
  task px(input [23:0] m, input [23:0] o, input [7:0] a, input on, input v, input f,
    input [23:0] ed, input ea);
    integer k;
  begin
    pm <= m;
    po <= o;
    pa <= a;
    pon <= on;
    pv <= v;
    pf <= f;
    k = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && k < 60)
    begin
      @(negedge clk);
      k = k + 1;
    end
    // A video clock that never comes is a failure, not a silent pass.
    if (k >= 60)
      err_count = err_count + 1;
    @(posedge clk);
    #1 chk(vo_data, ed);
    chk_pin(vo_valid, v);
    if (aux_on)
      chk_pin(aux, ea);
    @(posedge clk);
  end
  endtask

  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    ls <= 1'b1;
    @(posedge clk);
    run <= 1'b1;
    rd(`VOE_OFS_CTL, 32'h30000000);
    rd(`VOE_OFS_CLIP, 32'hf010eb10);
    rd(8'h40, 32'h0);
    wr(`VOE_OFS_CTL, 32'hf0000000);
    rd(`VOE_OFS_CTL, 32'h30000000);
    wr(`VOE_OFS_CTL, 32'h16);
    px(MA, OA, 8'ha0, 1'b1, 1'b1, 1'b0, ex(MA, OA, 9'h080), 1'b1);
    wr(`VOE_OFS_CTL, 32'h07);
    bd = 32'hf010eb10;
    px(MA, OA, 8'ha0, 1'b1, 1'b1, 1'b0, ex(MA, OA, 9'h0a1), 1'b1);
    wr(`VOE_OFS_CTL, 32'h01);
    bd = 32'hf010f010;
    px(MA, OA, 8'ha0, 1'b1, 1'b1, 1'b0, ex(MA, OA, 9'h080), 1'b1);
    wr(`VOE_OFS_CLIP, 32'hd030c020);
    wr(`VOE_OFS_CTL, 32'h05);
    bd = 32'hd030c020;
    px(24'he02818, 24'h000000, 8'h00, 1'b0, 1'b1, 1'b0,
      ex(24'he02818, 24'h000000, 9'h000), 1'b1);
    px(24'h8080c5, 24'h000000, 8'h00, 1'b0, 1'b1, 1'b0,
      ex(24'h8080c5, 24'h000000, 9'h000), 1'b1);
    wr(`VOE_OFS_CTL, 32'h07);
    px(24'h808030, 24'h808000, 8'h80, 1'b1, 1'b1, 1'b0,
      ex(24'h808030, 24'h808000, 9'h081), 1'b1);
    wr(`VOE_OFS_MASK, 32'h31000000);
    wr(`VOE_OFS_KEY, 32'h00776655);
    rd(`VOE_OFS_MASK, 32'h31000000);
    wr(`VOE_OFS_CTL, 32'h41);
    bd = 32'hf010f010;
    px(M0, 24'h766756, 8'hff, 1'b1, 1'b1, 1'b0, M0, 1'b1);
    rd(`VOE_OFS_STATUS, 32'h00000005);
    px(M0, 24'h766759, 8'hff, 1'b1, 1'b1, 1'b0, 24'h766759, 1'b1);
    px(M0, 24'h756756, 8'hff, 1'b1, 1'b1, 1'b0, 24'h756756, 1'b1);
    px(M0, 24'h766456, 8'hff, 1'b1, 1'b1, 1'b0, 24'h766456, 1'b1);
    wr(`VOE_OFS_CTL, 32'h01);
    px(M0, 24'h766756, 8'hff, 1'b1, 1'b1, 1'b0, 24'h766756, 1'b1);
    wr(`VOE_OFS_CTL, 32'h09);
    wr(`VOE_OFS_MODE, 32'h2);
    px(M0, M0, 8'h00, 1'b0, 1'b1, 1'b1, M0, 1'b1);
    px(24'h909090, M0, 8'h00, 1'b0, 1'b0, 1'b1, M0, 1'b0);
    ls <= 1'b0;
    wr(`VOE_OFS_MODE, 32'h0);
    px(M0, M0, 8'h00, 1'b0, 1'b1, 1'b1, M0, 1'b0);
    wr(`VOE_OFS_CTL, 32'h19);
    wr(`VOE_OFS_MODE, 32'h2);
    px(M0, M0, 8'h00, 1'b0, 1'b0, 1'b1, M0, 1'b1);
    px(M0, M0, 8'h00, 1'b0, 1'b1, 1'b0, M0, 1'b0);
    wr(`VOE_OFS_SLVDLY, 32'h3);
    wr(`VOE_OFS_MODE, 32'h0);
    wr(`VOE_OFS_CTL, 32'h31);
    for (i = 0; i < 12; i = i + 1)
    begin
      aux_on = (i >= 3);
      px(M0, M0, 8'h00, 1'b0, 1'b1, fp[i], M0, (i >= 3) ? fp[i - 3] : 1'b0);
    end
    wr(`VOE_OFS_MODE, 32'h1);
    px(M0, M0, 8'h00, 1'b0, 1'b1, 1'b1, M0, 1'b1);
    px(M0, M0, 8'h00, 1'b0, 1'b1, 1'b0, M0, 1'b0);
    chk_pin(taken != 16'h0, 1'b1);
    tally_and_finish;
  end

  // Watchdog well beyond the roughly 1.5 us the sequence needs.
  initial
  begin
    #100000;
    err_count = err_count + 1;
    tally_and_finish;
  end
endmodule // voe_ctl_tb
